// ### design/idr_top.v
`default_nettype none
`include "idr_consts.vh"
module idr_top #(
  parameter DEPTH = `IDR_RAM_BYTES
) (
  input  wire       i_clock,
  input  wire       i_reset_n,
  input  wire [2:0] i_op,
  input  wire [1:0] i_mode,
  input  wire       i_bit_op,
  input  wire [7:0] i_addr,
  input  wire [2:0] i_reg_sel,
  input  wire       i_ptr_sel,
  input  wire [7:0] i_wdata,
  input  wire       i_bit_wdata,
  input  wire [7:0] i_program_status_word,
  input  wire       i_sp_load,
  input  wire [7:0] i_sp_wdata,
  output reg        o_ack,
  output reg  [7:0] o_rdata,
  output reg        o_bit_rdata,
  output reg        o_sfr_req,
  output reg        o_sfr_we,
  output reg  [7:0] o_sfr_addr,
  output reg  [7:0] o_sfr_wdata,
  output reg  [7:0] o_stack_pointer
);
  // Sequencer states, one-hot
  // One-hot, yet every state test here compares all five flops of the code
  localparam [4:0] ST_IDLE  = 5'b00001;  // Waiting for a request
  localparam [4:0] ST_PTR   = 5'b00010;  // Fetching the indirect pointer
  localparam [4:0] ST_RD    = 5'b00100;  // RAM read in flight
  localparam [4:0] ST_RMW   = 5'b01000;  // Bit write merge step
  localparam [4:0] ST_DONE  = 5'b10000;  // Present answer

  // Request copies, so later states do not depend on the core's lines
  reg [4:0] state_r;       // Current state
  reg [4:0] state_nxt;     // Next state
  reg [2:0] op_r;          // Latched operation
  reg       bit_r;         // Latched operand type
  reg [2:0] bpos_r;        // Latched bit position
  reg       bwd_r;         // Latched bit write value
  reg [7:0] wd_r;          // Latched byte write value
  reg [7:0] ea_r;          // Effective RAM address
  reg [7:0] sp_r;          // Stack pointer

  // Memory port signals
  reg        ram_we;
  reg  [7:0] ram_addr;
  reg  [7:0] ram_wd;
  wire [7:0] ram_rd;

  // Decoded locations
  wire [1:0] bank = {i_program_status_word[`IDR_BANK_HI_POS],
                     i_program_status_word[`IDR_BANK_LO_POS]};
  wire [7:0] reg_addr;
  wire [7:0] ptr_addr;
  wire [7:0] bit_byte;
  wire [2:0] bit_pos;

  // True when the bit operand lies in the bit space of RAM, not SFRs
  function is_ram_bit;
    input [7:0] a;
    begin
      is_ram_bit = (a <= `IDR_LOW_TOP);
    end
  endfunction

  // Location of the bank register and of the bit named on the request lines
  idr_decode u_reg_dec (
    .i_bank     (bank),
    .i_reg      (i_reg_sel),
    .i_bit_addr (i_addr[6:0]),
    .o_reg_addr (reg_addr),
    .o_bit_byte (bit_byte),
    .o_bit_pos  (bit_pos)
  );

  // Pointer is register zero or one of the active bank
  idr_decode u_ptr_dec (
    .i_bank     (bank),
    .i_reg      ({2'b00, i_ptr_sel}),
    .i_bit_addr (7'h00),
    .o_reg_addr (ptr_addr),
    .o_bit_byte (),
    .o_bit_pos  ()
  );

  // Byte memory; read data arrive one cycle after the address
  idr_ram #(
    .DEPTH (DEPTH),
    .AW    (8)
  ) u_ram (
    .i_clock (i_clock),
    .i_we    (ram_we),
    .i_addr  (ram_addr),
    .i_wdata (ram_wd),
    .o_rdata (ram_rd)
  );

  // Bit merge for read-modify-write: only the addressed lane takes the new
  // value, the other seven write back what the read returned
  wire [7:0] lane_sel = 8'h01 << bpos_r;  // One-hot lane of the latched bit
  wire [7:0] merged;                       // Byte written back in the merge step
  genvar     g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_merge
      assign merged[g] = lane_sel[g] ? bwd_r : ram_rd[g];
    end
  endgenerate

  // Memory port steering and next state
  // The RAM address is steered in the same cycle as the state that needs it
  always @* begin
    state_nxt = state_r;
    ram_we    = 1'b0;
    ram_addr  = ea_r;
    ram_wd    = wd_r;
    case (state_r)
      ST_IDLE: begin
        // Push writes one above the pointer in the take cycle itself
        if (i_op == `IDR_OP_PUSH) begin
          ram_addr  = sp_r + 8'h01;
          ram_we    = 1'b1;
          ram_wd    = i_wdata;
          state_nxt = ST_DONE;
        end else if (i_op == `IDR_OP_POP) begin
          // Pop reads at the pointer; the byte comes back next cycle
          ram_addr  = sp_r;
          state_nxt = ST_RD;
        end else if (i_op == `IDR_OP_READ || i_op == `IDR_OP_WRITE) begin
          // Indirect: fetch the pointer register first, then the target
          if (i_mode == `IDR_MODE_INDIRECT) begin
            ram_addr  = ptr_addr;
            state_nxt = ST_PTR;
          end else if (i_bit_op) begin
            // Operand type, not address, picks bit handling
            if (is_ram_bit(i_addr)) begin
              ram_addr  = bit_byte;
              state_nxt = ST_RD;
            end else begin
              state_nxt = ST_DONE;
            end
          end else if (i_mode == `IDR_MODE_REGISTER) begin
            // Register of the active bank, byte access
            ram_addr = reg_addr;
            ram_we   = (i_op == `IDR_OP_WRITE);
            ram_wd   = i_wdata;
            state_nxt = (i_op == `IDR_OP_WRITE) ? ST_DONE : ST_RD;
          end else if (i_addr <= `IDR_LOW_TOP) begin
            // Direct byte in the lower half
            ram_addr = i_addr;
            ram_we   = (i_op == `IDR_OP_WRITE);
            ram_wd   = i_wdata;
            state_nxt = (i_op == `IDR_OP_WRITE) ? ST_DONE : ST_RD;
          end else begin
            // Direct above 0x7F never touches upper RAM
            state_nxt = ST_DONE;
          end
        end
      end
      ST_PTR: begin
        // Pointer byte now valid: any of 256 bytes is reachable
        ram_addr  = ram_rd;
        ram_we    = (op_r == `IDR_OP_WRITE);
        ram_wd    = wd_r;
        state_nxt = (op_r == `IDR_OP_WRITE) ? ST_DONE : ST_RD;
      end
      ST_RD: begin
        // A bit write goes on to the merge, everything else answers
        state_nxt = (bit_r && op_r == `IDR_OP_WRITE) ? ST_RMW : ST_DONE;
      end
      ST_RMW: begin
        ram_we    = 1'b1;
        ram_wd    = merged;
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        // Answer cycle, then back to idle
        state_nxt = ST_IDLE;
      end
      default: begin
        // Illegal code: recover to idle
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // A request is taken only in idle; while busy the op lines are ignored
  wire take     = (state_r == ST_IDLE) && (i_op != `IDR_OP_NONE);
  // Read or write, byte or bit, on the request lines
  wire rw_op    = (i_op == `IDR_OP_READ) || (i_op == `IDR_OP_WRITE);
  // Direct byte above the lower half is an SFR cycle, never upper RAM
  wire sfr_byte = rw_op && (i_mode == `IDR_MODE_DIRECT) && !i_bit_op && (i_addr > `IDR_LOW_TOP);
  // Bit operand above 0x7F lies in SFR bit space; indirect ignores the bit flag
  wire sfr_bit  = rw_op && i_bit_op && (i_mode != `IDR_MODE_INDIRECT) && !is_ram_bit(i_addr);

  // Sequencer state and the request fields latched at the take edge
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= ST_IDLE;
      op_r    <= `IDR_OP_NONE;
      bit_r   <= 1'b0;
      bpos_r  <= 3'h0;
      bwd_r   <= 1'b0;
      wd_r    <= 8'h00;
      ea_r    <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (take) begin
        // Later states work from these copies, so the core may move its lines
        op_r   <= i_op;
        bit_r  <= i_bit_op && i_mode != `IDR_MODE_INDIRECT;
        bpos_r <= bit_pos;
        bwd_r  <= i_bit_wdata;
        wd_r   <= i_wdata;
        ea_r   <= ram_addr;
      end else if (state_r == ST_PTR) begin
        // Pointer byte arrives from RAM and becomes the target address
        ea_r <= ram_rd;
      end
    end
  end

  // Stack pointer: steps on push and pop, loads from the core when idle
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sp_r            <= `IDR_SP_RESET;
      o_stack_pointer <= `IDR_SP_RESET;
    end else if (state_r == ST_IDLE) begin
      if (i_op == `IDR_OP_PUSH) begin
        // Wraps from 0xFF to 0x00, so the whole memory can hold the stack
        sp_r            <= sp_r + 8'h01;
        o_stack_pointer <= sp_r + 8'h01;
      end else if (i_op == `IDR_OP_POP) begin
        sp_r            <= sp_r - 8'h01;
        o_stack_pointer <= sp_r - 8'h01;
      end else if (i_sp_load) begin
        // A load beside a push or pop is dropped; the core never asks for both
        sp_r            <= i_sp_wdata;
        o_stack_pointer <= i_sp_wdata;
      end
    end
  end

  // Special register cycle: one-cycle request with address and data beside it
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sfr_req   <= 1'b0;
      o_sfr_we    <= 1'b0;
      o_sfr_addr  <= 8'h00;
      o_sfr_wdata <= 8'h00;
    end else begin
      o_sfr_req <= 1'b0;
      o_sfr_we  <= 1'b0;
      if (take && sfr_byte) begin
        o_sfr_req   <= 1'b1;
        o_sfr_we    <= (i_op == `IDR_OP_WRITE);
        o_sfr_addr  <= i_addr;
        o_sfr_wdata <= i_wdata;
      end else if (take && sfr_bit) begin
        // Bit cycle names the byte that holds the bit
        o_sfr_req   <= 1'b1;
        o_sfr_we    <= (i_op == `IDR_OP_WRITE);
        o_sfr_addr  <= {i_addr[7:3], 3'b000};
        o_sfr_wdata <= i_wdata;
      end
    end
  end

  // Answer side: read byte, selected bit and the completion pulse
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ack       <= 1'b0;
      o_rdata     <= 8'h00;
      o_bit_rdata <= 1'b0;
    end else begin
      // Read data hold until the next RAM read or RAM bit write, so the core may pick them up late
      if (state_r == ST_RD) begin
        o_rdata     <= ram_rd;
        o_bit_rdata <= ram_rd[bpos_r];
      end
      o_ack <= (state_r == ST_DONE);
    end
  end
endmodule
`default_nettype wire

// ### design/idr_consts.vh
`ifndef IDR_CONSTS_VH
`define IDR_CONSTS_VH
// Memory size and address regions
`define IDR_RAM_BYTES      256
`define IDR_LOW_TOP        8'h7F
`define IDR_BANK_TOP       8'h1F
`define IDR_BIT_BASE       8'h20
`define IDR_BIT_BASE_HI    4'h2
// Field positions in the program status word
`define IDR_BANK_LO_POS    3
`define IDR_BANK_HI_POS    4
// Stack pointer reset value
`define IDR_SP_RESET       8'h07
// Access operation codes
`define IDR_OP_NONE        3'h0
`define IDR_OP_READ        3'h1
`define IDR_OP_WRITE       3'h2
`define IDR_OP_PUSH        3'h3
`define IDR_OP_POP         3'h4
// Addressing modes
`define IDR_MODE_DIRECT    2'h0
`define IDR_MODE_INDIRECT  2'h1
`define IDR_MODE_REGISTER  2'h2
`endif

// ### design/idr_ram.v
`default_nettype none
// Single-port byte memory, registered read data
module idr_ram #(
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  input  wire          i_clock,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [7:0]    i_wdata,
  output reg  [7:0]    o_rdata
);
  // Storage array; no reset so it maps onto a real RAM macro
  reg [7:0] mem [0:DEPTH-1];

  // Read-first: write into the array, read old contents out of a register
  always @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ### design/idr_decode.v
`default_nettype none
`include "idr_consts.vh"
// Pure address decode: bank register location and bit location
module idr_decode (
  input  wire [1:0] i_bank,
  input  wire [2:0] i_reg,
  input  wire [6:0] i_bit_addr,
  output wire [7:0] o_reg_addr,
  output wire [7:0] o_bit_byte,
  output wire [2:0] o_bit_pos
);
  // Register n of bank k sits at 8*k + n
  assign o_reg_addr = {3'b000, i_bank, i_reg};
  // Bits ascend: upper four bits pick byte 0x20..0x2F, low three pick the bit
  assign o_bit_byte = {`IDR_BIT_BASE_HI, i_bit_addr[6:3]};
  assign o_bit_pos  = i_bit_addr[2:0];
endmodule
`default_nettype wire

// ### bench/idr_top_properties.sv
`default_nettype none
`include "idr_consts.vh"
// Protocol checks on the memory block ports
module idr_top_properties (
  input wire logic       i_clock,
  input wire logic       i_reset_n,
  input wire logic [2:0] i_op,
  input wire logic [1:0] i_mode,
  input wire logic       o_ack,
  input wire logic       o_sfr_req,
  input wire logic [7:0] o_sfr_addr,
  input wire logic [7:0] o_stack_pointer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Pointer is still at its reset value at the first edge after release
  a_reset_sp_value: assert property (!$past(i_reset_n) |-> o_stack_pointer == 8'h07)
    else $error("stack pointer not at reset value");
  a_ack_one_cycle: assert property (o_ack |=> !o_ack)
    else $error("ack longer than one cycle");
  a_sfr_one_cycle: assert property (o_sfr_req |=> !o_sfr_req)
    else $error("special register request too long");
  a_sfr_upper_half: assert property (o_sfr_req |-> o_sfr_addr[7])
    else $error("special register request below upper half");
  // Indirect mode must never leave the memory
  a_sfr_direct_only: assert property (o_sfr_req |-> $past(i_mode) == `IDR_MODE_DIRECT)
    else $error("special register request outside direct mode");
  a_push_step_up: assert property ($past(i_op) == `IDR_OP_PUSH && $changed(o_stack_pointer)
    |-> o_stack_pointer == $past(o_stack_pointer) + 8'h01 ##1 o_ack)
    else $error("push did not step pointer up then ack");
  a_pop_step_down: assert property ($past(i_op) == `IDR_OP_POP && $changed(o_stack_pointer)
    |-> o_stack_pointer == $past(o_stack_pointer) - 8'h01)
    else $error("pop did not step pointer down");
  a_ack_with_op: assert property (o_ack |-> $past(i_op, 2) != `IDR_OP_NONE)
    else $error("ack without a request");
  c_sfr: cover property (o_sfr_req);
  c_push: cover property (i_op == `IDR_OP_PUSH && o_ack);
  c_indirect: cover property (i_mode == `IDR_MODE_INDIRECT && o_ack);
endmodule
bind idr_top idr_top_properties idr_top_properties_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
  .i_op(i_op), .i_mode(i_mode), .o_ack(o_ack), .o_sfr_req(o_sfr_req), .o_sfr_addr(o_sfr_addr),
  .o_stack_pointer(o_stack_pointer));
`default_nettype wire

// ### bench/idr_sfr_model.sv
`default_nettype none
// Special register space seen from the memory block: counts and records writes
module idr_sfr_model (
  input  wire logic       i_clock,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output var  logic [7:0] o_count,
  output var  logic [7:0] o_last_addr,
  output var  logic [7:0] o_last_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_count = 8'h00;
    o_last_addr = 8'h00;
    o_last_data = 8'h00;
  end
  // Writes above the lower half land here, apart from the upper memory
  always @(posedge i_clock) begin
    if (i_req && i_we) begin
      o_count <= o_count + 8'h01;
      o_last_addr <= i_addr;
      o_last_data <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// ### bench/test_internal_data_ram_addressing.sv
`default_nettype none
`include "idr_consts.vh"
module test_internal_data_ram_addressing;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] op; logic [1:0] md; logic bo; logic [7:0] ad;
    logic [2:0] rg; logic pt; logic [7:0] program_status_word; logic [7:0] wd; logic bw; logic [7:0] ex;} idr_row_t;
  logic i_clock = 1, i_reset_n = 1, i_bit_op = 0, i_ptr_sel = 0, i_bit_wdata = 0, i_sp_load = 0;
  logic [2:0] i_op = 0, i_reg_sel = 0;
  logic [1:0] i_mode = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, i_program_status_word = 0, i_sp_wdata = 0;
  logic o_ack, o_bit_rdata, o_sfr_req, o_sfr_we;
  logic [7:0] o_rdata, o_sfr_addr, o_sfr_wdata, o_stack_pointer, sfr_count, sfr_addr, sfr_data;
  int num_errors = 0, checked = 0;
  idr_row_t rows [9];
  always #2.5 i_clock = ~i_clock;
  idr_top idr_top_inst (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_op(i_op), .i_mode(i_mode),
    .i_bit_op(i_bit_op), .i_addr(i_addr), .i_reg_sel(i_reg_sel), .i_ptr_sel(i_ptr_sel), .i_wdata(i_wdata),
    .i_bit_wdata(i_bit_wdata), .i_program_status_word(i_program_status_word), .i_sp_load(i_sp_load),
    .i_sp_wdata(i_sp_wdata), .o_ack(o_ack), .o_rdata(o_rdata), .o_bit_rdata(o_bit_rdata),
    .o_sfr_req(o_sfr_req), .o_sfr_we(o_sfr_we), .o_sfr_addr(o_sfr_addr), .o_sfr_wdata(o_sfr_wdata),
    .o_stack_pointer(o_stack_pointer));
  idr_sfr_model idr_sfr_model_inst (.i_clock(i_clock), .i_req(o_sfr_req), .i_we(o_sfr_we),
    .i_addr(o_sfr_addr), .i_wdata(o_sfr_wdata), .o_count(sfr_count), .o_last_addr(sfr_addr),
    .o_last_data(sfr_data));
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t byte got %h want %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  // One whole request: raise at a falling edge, hold until ack, drop after
  task run(input idr_row_t r);
    int n;
    @(negedge i_clock);
    {i_op, i_mode, i_bit_op, i_addr, i_reg_sel} = {r.op, r.md, r.bo, r.ad, r.rg};
    {i_ptr_sel, i_program_status_word, i_wdata, i_bit_wdata} = {r.pt, r.program_status_word, r.wd, r.bw};
    n = 0;
    do begin
      @(posedge i_clock);
      #1;
      n++;
    end while (o_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("BAD %0t no ack", $time);
      wrap_up();
    end else begin
      @(negedge i_clock);
      i_op = `IDR_OP_NONE;
    end
  endtask
  // Pointer load is a one-cycle strobe while idle
  task sp_set(input logic [7:0] v);
    @(negedge i_clock);
    {i_sp_load, i_sp_wdata} = {1'b1, v};
    @(negedge i_clock);
    i_sp_load = 1'b0;
  endtask
  initial begin
    rows[0] = '{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 0, 8'h05, 0, 0, 8'h00, 8'hA5, 0, 8'h00};
    rows[1] = '{`IDR_OP_READ, `IDR_MODE_REGISTER, 0, 8'h00, 5, 0, 8'h00, 8'h00, 0, 8'hA5};
    rows[2] = '{`IDR_OP_WRITE, `IDR_MODE_REGISTER, 0, 8'h00, 7, 0, 8'h18, 8'h3C, 0, 8'h00};
    rows[3] = '{`IDR_OP_READ, `IDR_MODE_DIRECT, 0, 8'h1F, 0, 0, 8'h00, 8'h00, 0, 8'h3C};
    rows[4] = '{`IDR_OP_WRITE, `IDR_MODE_REGISTER, 0, 8'h00, 1, 0, 8'h08, 8'h90, 0, 8'h00};
    rows[5] = '{`IDR_OP_WRITE, `IDR_MODE_INDIRECT, 0, 8'h00, 0, 1, 8'h08, 8'h77, 0, 8'h00};
    rows[6] = '{`IDR_OP_READ, `IDR_MODE_INDIRECT, 0, 8'h00, 0, 1, 8'h08, 8'h00, 0, 8'h77};
    rows[7] = '{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 0, 8'h2F, 0, 0, 8'h00, 8'h80, 0, 8'h00};
    rows[8] = '{`IDR_OP_READ, `IDR_MODE_DIRECT, 0, 8'h2F, 0, 0, 8'h00, 8'h00, 0, 8'h80};
    // Pull reset low at the first falling edge so the design sees an edge
    @(negedge i_clock);
    i_reset_n = 1'b0;
    repeat (16) @(negedge i_clock);
    i_reset_n = 1;
    chk8(o_stack_pointer, 8'h07);
    $display("reset test done");
    foreach (rows[k]) begin
      run(rows[k]);
      if (rows[k].op == `IDR_OP_READ) chk8(o_rdata, rows[k].ex);
    end
    $display("table test done");
    // Top bit of the last bit byte, then a single-bit write into the first
    run('{`IDR_OP_READ, `IDR_MODE_DIRECT, 1, 8'h7F, 0, 0, 8'h00, 8'h00, 0, 8'h00});
    chk1(o_bit_rdata, 1'b1);
    // Memory is not cleared by reset, so give the target byte a known value first
    run('{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 0, 8'h20, 0, 0, 8'h00, 8'hA4, 0, 8'h00});
    run('{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 1, 8'h00, 0, 0, 8'h00, 8'h00, 1, 8'h00});
    run('{`IDR_OP_READ, `IDR_MODE_DIRECT, 0, 8'h20, 0, 0, 8'h00, 8'h00, 0, 8'h00});
    chk8(o_rdata, 8'hA5);
    $display("bit test done");
    // Direct write to the upper address must not reach the memory byte
    run('{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 0, 8'h90, 0, 0, 8'h00, 8'hEE, 0, 8'h00});
    chk8(sfr_count, 8'h01);
    chk8(sfr_addr, 8'h90);
    chk8(sfr_data, 8'hEE);
    // Bit operand above 0x7F is an SFR bit: the cycle names its byte
    run('{`IDR_OP_WRITE, `IDR_MODE_DIRECT, 1, 8'hA3, 0, 0, 8'h00, 8'h00, 1, 8'h00});
    chk8(sfr_count, 8'h02);
    chk8(sfr_addr, 8'hA0);
    run(rows[6]);
    chk8(o_rdata, 8'h77);
    $display("upper half test done");
    // First push lands on bank one register zero
    run('{`IDR_OP_PUSH, `IDR_MODE_DIRECT, 0, 8'h00, 0, 0, 8'h00, 8'h11, 0, 8'h00});
    chk8(o_stack_pointer, 8'h08);
    run('{`IDR_OP_READ, `IDR_MODE_REGISTER, 0, 8'h00, 0, 0, 8'h08, 8'h00, 0, 8'h00});
    chk8(o_rdata, 8'h11);
    run('{`IDR_OP_POP, `IDR_MODE_DIRECT, 0, 8'h00, 0, 0, 8'h00, 8'h00, 0, 8'h00});
    chk8(o_rdata, 8'h11);
    chk8(o_stack_pointer, 8'h07);
    // Stack at the very top of memory
    sp_set(8'hFE);
    run('{`IDR_OP_PUSH, `IDR_MODE_DIRECT, 0, 8'h00, 0, 0, 8'h00, 8'h5A, 0, 8'h00});
    chk8(o_stack_pointer, 8'hFF);
    run('{`IDR_OP_POP, `IDR_MODE_DIRECT, 0, 8'h00, 0, 0, 8'h00, 8'h00, 0, 8'h00});
    chk8(o_rdata, 8'h5A);
    $display("stack test done");
    // Any reset, also one in mid-run, puts the pointer back
    @(negedge i_clock);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    chk8(o_stack_pointer, 8'h07);
    $display("second reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
